// file: lpi_pkg.sv
// Shared constants, commands and states of the memory init link
package lpi_pkg;
   localparam int          CLK_PERIOD_PS      = 5000;
   localparam int          CKE_LOW_WAIT_NS    = 100;
   localparam int          CLOCK_STABLE_WAIT  = 5;
   localparam int          POST_CKE_IDLE_US   = 200;
   localparam int          POST_RESET_US      = 1;
   localparam int          AUTO_INIT_MAX_US   = 10;
   localparam int          BOOT_CLK_MIN_NS    = 18;
   localparam int          BOOT_CLK_MAX_NS    = 100;
   localparam int          CKE_LOW_CYC        = (CKE_LOW_WAIT_NS * 1000 + CLK_PERIOD_PS - 1)
                                                / CLK_PERIOD_PS;
   localparam int          POST_CKE_CYC       = POST_CKE_IDLE_US * 1000000 / CLK_PERIOD_PS;
   localparam int          POST_RESET_CYC     = POST_RESET_US * 1000000 / CLK_PERIOD_PS;
   localparam int          AUTO_INIT_CYC      = AUTO_INIT_MAX_US * 1000000 / CLK_PERIOD_PS;
   localparam int          BOOT_DIV           = (BOOT_CLK_MIN_NS * 1000 + 2 * CLK_PERIOD_PS - 1)
                                                / (2 * CLK_PERIOD_PS);
   localparam int          DAI_BUSY_CYC       = 64;
   localparam logic [7:0]  MA_INIT_STATUS     = 8'h00;
   localparam logic [7:0]  MA_BURST           = 8'h01;
   localparam logic [7:0]  MA_LATENCY         = 8'h02;
   localparam logic [7:0]  MA_DRIVE           = 8'h03;
   localparam logic [7:0]  MA_REFRESH         = 8'h04;
   localparam logic [7:0]  MA_MAKER           = 8'h05;
   localparam logic [7:0]  MA_REV_ONE         = 8'h06;
   localparam logic [7:0]  MA_REV_TWO         = 8'h07;
   localparam logic [7:0]  MA_GEOMETRY        = 8'h08;
   localparam logic [7:0]  MA_TEST_MODE       = 8'h09;
   localparam logic [7:0]  MA_IO_CALIB        = 8'h0a;
   localparam logic [7:0]  MA_BANK_MASK       = 8'h10;
   localparam logic [7:0]  MA_SEG_MASK        = 8'h11;
   localparam logic [7:0]  MA_CAL_A           = 8'h20;
   localparam logic [7:0]  MA_CAL_B           = 8'h28;
   localparam logic [7:0]  MA_SOFT_RESET      = 8'h3f;
   localparam logic [7:0]  BURST_RESET        = 8'h22;
   localparam logic [7:0]  LATENCY_RESET      = 8'h01;
   localparam logic [7:0]  DRIVE_RESET        = 8'h02;
   localparam int          AUTO_INIT_BIT      = 0;
   localparam int          DEVICE_KIND_BIT    = 1;
   localparam int          FAIL_DIE_BIT       = 5;
   localparam logic [7:0]  CAL_A_VALUE        = 8'h00;
   localparam logic [7:0]  CAL_B_VALUE        = 8'h00;
   localparam logic [7:0]  REFRESH_VALUE      = 8'h03;
   localparam logic [7:0]  GEOMETRY_VALUE     = 8'h10;
   localparam logic [11:0] APB_CTRL           = 12'h000;
   localparam logic [11:0] APB_STATUS         = 12'h004;
   localparam logic [11:0] APB_MRCMD          = 12'h008;
   localparam logic [11:0] APB_MRDATA         = 12'h00c;
   localparam int          CTRL_START         = 0;
   localparam int          CTRL_CKE_OFF       = 1;
   localparam int          CMD_GO             = 31;
   localparam int          CMD_WRITE          = 16;
   typedef enum logic [2:0]
   {
      CMD_NOP = 3'b000,
      CMD_MRW = 3'b001,
      CMD_MRR = 3'b010,
      CMD_PDE = 3'b011,
      CMD_PDX = 3'b100
   } lpi_cmd_t;
   typedef enum logic [3:0]
   {
      ST_OFF    = 4'b0000,
      ST_CKELOW = 4'b0001,
      ST_CKEON  = 4'b0010,
      ST_IDLE3  = 4'b0011,
      ST_RESET  = 4'b0100,
      ST_WAIT4  = 4'b0101,
      ST_POLL   = 4'b0110,
      ST_PWAIT  = 4'b0111,
      ST_READY  = 4'b1000,
      ST_USER   = 4'b1001,
      ST_UWAIT  = 4'b1010
   } lpi_state_t;
endpackage

// file: lpi_link_if.sv
// Command link between init controller and memory device
`timescale 1ns/10ps
`default_nettype none
interface lpi_link_if;
   logic            mem_clk;
   logic            cke;
   logic            cs_n;
   lpi_pkg::lpi_cmd_t cmd;
   logic [7:0]      ma;
   logic [7:0]      op;
   logic [7:0]      rd_data;
   logic            rd_valid;
   logic            rd_oe_n;
   modport ctrl (output mem_clk, output cke, output cs_n, output cmd, output ma, output op,
                 input rd_data, input rd_valid, input rd_oe_n);
   modport dev  (input mem_clk, input cke, input cs_n, input cmd, input ma, input op,
                 output rd_data, output rd_valid, output rd_oe_n);
endinterface
`default_nettype wire

// file: lpi_sync2.sv
// Two-flop synchroniser for link inputs
`timescale 1ns/10ps
`default_nettype none
module lpi_sync2 #(
   parameter int W = 1
) (
   input  wire logic         CORE_CLK,
   input  wire logic         RST_N,
   input  wire logic [W-1:0] D,
   output logic      [W-1:0] Q
);
   logic [W-1:0] meta_q;
   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         meta_q <= '0;
         Q      <= '0;
      end
      else
      begin
         meta_q <= D;
         Q      <= meta_q;
      end
   end
endmodule
`default_nettype wire

// file: lpi_mem_dev.sv
// Memory device end: mode registers and auto-initialisation
`timescale 1ns/10ps
`default_nettype none
module lpi_mem_dev #(
   parameter int         BUSY_CYC   = lpi_pkg::DAI_BUSY_CYC,
   parameter logic [7:0] MAKER_CODE = 8'h5a, // Arbitrary value
   parameter logic [7:0] REV_ONE    = 8'h11, // Arbitrary value
   parameter logic [7:0] REV_TWO    = 8'h22  // Arbitrary value
) (
   input  wire logic       CORE_CLK,
   input  wire logic       RST_N,
   lpi_link_if.dev         LINK,
   input  wire logic       FAIL_DIE,
   output logic            INIT_BUSY,
   output logic      [2:0] BURST_LEN_CODE,
   output logic            BURST_ORDER,
   output logic            WRAP_OFF,
   output logic      [2:0] WRITE_RECOVERY,
   output logic      [3:0] LATENCY_CODE,
   output logic      [3:0] DRIVE_CODE
);
   logic        clk_s, cke_s, cs_n_s;
   logic        fail_die_s;
   logic [2:0]  cmd_s;
   logic [7:0]  ma_s, op_s;
   logic        clk_prev_q;
   logic        edge_w;
   logic        busy_q;
   logic [15:0] busy_cnt_q;
   logic [7:0]  burst_q, latency_q, drive_q;
   logic [7:0]  rd_q;
   logic        rd_valid_q;
   logic        oe_n_q;
   logic        wr_w, rd_w, reset_w;

   lpi_sync2 #(.W(22)) u_sync (
      .CORE_CLK (CORE_CLK),
      .RST_N    (RST_N),
      .D        ({LINK.mem_clk, LINK.cke, LINK.cs_n, LINK.cmd, LINK.ma, LINK.op}),
      .Q        ({clk_s, cke_s, cs_n_s, cmd_s, ma_s, op_s})
   );

   // The failed-die level comes from a pin outside the clock domain
   lpi_sync2 #(.W(1)) u_fail_sync (
      .CORE_CLK (CORE_CLK),
      .RST_N    (RST_N),
      .D        (FAIL_DIE),
      .Q        (fail_die_s)
   );

   // Commands are taken on a rising edge of the link clock with enable high
   assign edge_w  = clk_s && !clk_prev_q && cke_s && !cs_n_s;
   assign wr_w    = edge_w && cmd_s == 3'(lpi_pkg::CMD_MRW);
   assign rd_w    = edge_w && cmd_s == 3'(lpi_pkg::CMD_MRR);
   assign reset_w = wr_w && ma_s == lpi_pkg::MA_SOFT_RESET;

   // Only the three configuration registers and the reset command take writes; all else is read-only or reserved
   function automatic logic writable(input logic [7:0] a);
      writable = (a == lpi_pkg::MA_BURST) || (a == lpi_pkg::MA_LATENCY) ||
                 (a == lpi_pkg::MA_DRIVE);
   endfunction

   // One status bit placed in an otherwise clear register byte
   function automatic logic [7:0] one_bit(input int pos, input logic val);
      one_bit      = 8'h00;
      one_bit[pos] = val;
   endfunction

   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
         clk_prev_q <= 1'b0;
      else
         clk_prev_q <= clk_s;
   end

   // Busy from power-up and after every reset; clears well inside the limit
   // A reset in mid-count starts the count again from zero
   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         busy_q     <= 1'b1;
         busy_cnt_q <= '0;
      end
      else if (reset_w)
      begin
         busy_q     <= 1'b1;
         busy_cnt_q <= '0;
      end
      else if (busy_q && busy_cnt_q >= 16'(BUSY_CYC - 1))
         busy_q <= 1'b0;
      else if (busy_q)
         busy_cnt_q <= busy_cnt_q + 16'h0001;
   end

   // Configuration fields; a reset restores defaults before busy clears
   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         burst_q   <= lpi_pkg::BURST_RESET;
         latency_q <= lpi_pkg::LATENCY_RESET;
         drive_q   <= lpi_pkg::DRIVE_RESET;
      end
      else if (reset_w)
      begin
         burst_q   <= lpi_pkg::BURST_RESET;
         latency_q <= lpi_pkg::LATENCY_RESET;
         drive_q   <= lpi_pkg::DRIVE_RESET;
      end
      else if (wr_w && !busy_q && writable(ma_s))
      begin
         // Reserved codes are dropped so the fields always hold a legal value
         if (ma_s == lpi_pkg::MA_BURST && op_s[2:0] >= 3'h2 && op_s[2:0] <= 3'h4 &&
             op_s[7:5] >= 3'h1 && op_s[7:5] <= 3'h6)
            burst_q <= op_s;
         if (ma_s == lpi_pkg::MA_LATENCY && op_s[3:0] >= 4'h1 && op_s[3:0] <= 4'h6)
            latency_q <= {4'h0, op_s[3:0]};
         if (ma_s == lpi_pkg::MA_DRIVE && op_s[3:0] >= 4'h1 && op_s[3:0] <= 4'h7 &&
             op_s[3:0] != 4'h5)
            drive_q <= {4'h0, op_s[3:0]};
      end
   end

   // Read path over the full address space; reserved and write-only read zero
   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         rd_q       <= 8'h00;
         rd_valid_q <= 1'b0;
      end
      else
      begin
         // Valid lasts one cycle; read data holds until the next read
         rd_valid_q <= rd_w;
         if (rd_w)
         begin
            if (ma_s == lpi_pkg::MA_INIT_STATUS)
               rd_q <= one_bit(lpi_pkg::AUTO_INIT_BIT, busy_q);
            else if (ma_s == lpi_pkg::MA_REFRESH)
               rd_q <= lpi_pkg::REFRESH_VALUE;
            else if (ma_s == lpi_pkg::MA_MAKER)
               rd_q <= MAKER_CODE;
            else if (ma_s == lpi_pkg::MA_REV_ONE)
               rd_q <= REV_ONE;
            else if (ma_s == lpi_pkg::MA_REV_TWO)
               rd_q <= REV_TWO;
            else if (ma_s == lpi_pkg::MA_GEOMETRY)
               rd_q <= lpi_pkg::GEOMETRY_VALUE;
            else if (ma_s == lpi_pkg::MA_TEST_MODE)
               rd_q <= one_bit(lpi_pkg::FAIL_DIE_BIT, fail_die_s);
            else if (ma_s == lpi_pkg::MA_CAL_A)
               rd_q <= lpi_pkg::CAL_A_VALUE;
            else if (ma_s == lpi_pkg::MA_CAL_B)
               rd_q <= lpi_pkg::CAL_B_VALUE;
            else
               rd_q <= 8'h00;
         end
      end
   end

   // Output enable is low only while driving read data with enable high
   // A read that arrives with enable low never turns the driver on
   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
         oe_n_q <= 1'b1;
      else
         oe_n_q <= !(rd_w && cke_s);
   end

   // Configuration fields leave as levels for the data path
   assign LINK.rd_data  = rd_q;
   assign LINK.rd_valid = rd_valid_q;
   assign LINK.rd_oe_n  = oe_n_q;
   assign INIT_BUSY      = busy_q;
   assign BURST_LEN_CODE = burst_q[2:0];
   assign BURST_ORDER    = burst_q[3];
   assign WRAP_OFF       = burst_q[4];
   assign WRITE_RECOVERY = burst_q[7:5];
   assign LATENCY_CODE   = latency_q[3:0];
   assign DRIVE_CODE     = drive_q[3:0];
endmodule
`default_nettype wire

// file: lpi_init_ctrl.sv
// Controller end: power-up sequencer and register command port over APB
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module lpi_init_ctrl #(
   parameter int POST_CKE_CYC   = lpi_pkg::POST_CKE_CYC,
   parameter int POST_RESET_CYC = lpi_pkg::POST_RESET_CYC
) (
   input  wire logic        CORE_CLK,
   input  wire logic        RST_N,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   lpi_link_if.ctrl         LINK
);
   lpi_pkg::lpi_state_t st_q;
   logic [19:0] cnt_q;
   logic [7:0]  div_q;
   logic        mclk_q, cke_q, cs_n_q, rise_w;
   lpi_pkg::lpi_cmd_t cmd_q;
   logic [7:0]  ma_q, op_q, rdat_q;
   logic        start_q, off_q, go_q, uwr_q, done_q;
   logic [7:0]  uma_q, uop_q;
   logic        rv_s, wr_acc, rd_acc;
   logic [7:0]  rdat_s;

   lpi_sync2 #(.W(9)) u_sync (
      .CORE_CLK (CORE_CLK),
      .RST_N    (RST_N),
      .D        ({LINK.rd_valid, LINK.rd_data}),
      .Q        ({rv_s, rdat_s})
   );

   // Boot clock divided down to stay inside the slow boot window
   assign rise_w = (div_q == 8'(lpi_pkg::BOOT_DIV - 1)) && !mclk_q;
   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         div_q  <= 8'h00;
         mclk_q <= 1'b0;
      end
      else if (div_q == 8'(lpi_pkg::BOOT_DIV - 1))
      begin
         div_q  <= 8'h00;
         mclk_q <= !mclk_q;
      end
      else
         div_q <= div_q + 8'h01;
   end

   assign wr_acc = PSEL && PENABLE && PWRITE;
   // Read data is loaded in the setup cycle so it stands at the completing edge
   assign rd_acc = PSEL && !PENABLE && !PWRITE;
   assign PREADY  = 1'b1;
   assign PSLVERR = 1'b0;

   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         start_q <= 1'b0;
         off_q   <= 1'b0;
         uma_q   <= 8'h00;
         uop_q   <= 8'h00;
         uwr_q   <= 1'b0;
      end
      else if (wr_acc && PADDR == lpi_pkg::APB_CTRL)
      begin
         start_q <= PWDATA[lpi_pkg::CTRL_START];
         off_q   <= PWDATA[lpi_pkg::CTRL_CKE_OFF];
      end
      else if (wr_acc && PADDR == lpi_pkg::APB_MRCMD)
      begin
         uma_q <= PWDATA[15:8];
         uop_q <= PWDATA[7:0];
         uwr_q <= PWDATA[lpi_pkg::CMD_WRITE];
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
         PRDATA <= 32'h0000_0000;
      else if (rd_acc && PADDR == lpi_pkg::APB_CTRL)
         PRDATA <= {30'h0, off_q, start_q};
      else if (rd_acc && PADDR == lpi_pkg::APB_STATUS)
         PRDATA <= {22'h0, go_q, done_q, 4'h0, st_q};
      else if (rd_acc && PADDR == lpi_pkg::APB_MRCMD)
         PRDATA <= {go_q, 14'h0, uwr_q, uma_q, uop_q};
      else if (rd_acc && PADDR == lpi_pkg::APB_MRDATA)
         PRDATA <= {24'h0, rdat_q};
      else if (rd_acc)
         PRDATA <= 32'h0000_0000;
   end

   // Sequencer; commands change only on a link clock rising point
   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         st_q   <= lpi_pkg::ST_OFF;
         cnt_q  <= '0;
         cke_q  <= 1'b0;
         cs_n_q <= 1'b1;
         cmd_q  <= lpi_pkg::CMD_NOP;
         ma_q   <= 8'h00;
         op_q   <= 8'h00;
         done_q <= 1'b0;
         go_q   <= 1'b0;
         rdat_q <= 8'h00;
      end
      else
      begin
         if (rv_s)
            rdat_q <= rdat_s;
         if (off_q)
         begin
            st_q   <= lpi_pkg::ST_OFF;
            cke_q  <= 1'b0;
            cs_n_q <= 1'b1;
            done_q <= 1'b0;
         end
         else if (rise_w)
         begin
            cmd_q  <= lpi_pkg::CMD_NOP;
            cs_n_q <= 1'b1;
            cnt_q  <= cnt_q + 20'h1;
            case (st_q)
               lpi_pkg::ST_OFF:
                  if (start_q)
                  begin
                     st_q  <= lpi_pkg::ST_CKELOW;
                     cnt_q <= '0;
                  end
               lpi_pkg::ST_CKELOW:
                  // Edges counted cover both the low time and the stable clock
                  if (cnt_q >= 20'(lpi_pkg::CKE_LOW_CYC + lpi_pkg::CLOCK_STABLE_WAIT))
                  begin
                     cke_q <= 1'b1;
                     cnt_q <= '0;
                     st_q  <= lpi_pkg::ST_IDLE3;
                  end
               lpi_pkg::ST_IDLE3:
                  if (cnt_q >= 20'(POST_CKE_CYC / lpi_pkg::BOOT_DIV / 2))
                     st_q <= lpi_pkg::ST_RESET;
               lpi_pkg::ST_RESET:
               begin
                  cmd_q  <= lpi_pkg::CMD_MRW;
                  cs_n_q <= 1'b0;
                  ma_q   <= lpi_pkg::MA_SOFT_RESET;
                  done_q <= 1'b0;
                  cnt_q  <= '0;
                  st_q   <= lpi_pkg::ST_WAIT4;
               end
               lpi_pkg::ST_WAIT4:
                  if (cnt_q >= 20'(POST_RESET_CYC / lpi_pkg::BOOT_DIV / 2))
                     st_q <= lpi_pkg::ST_POLL;
               lpi_pkg::ST_POLL:
               begin
                  cmd_q  <= lpi_pkg::CMD_MRR;
                  cs_n_q <= 1'b0;
                  ma_q   <= lpi_pkg::MA_INIT_STATUS;
                  cnt_q  <= '0;
                  st_q   <= lpi_pkg::ST_PWAIT;
               end
               lpi_pkg::ST_PWAIT:
                  if (cnt_q >= 20'h4)
                  begin
                     if (rdat_q[lpi_pkg::AUTO_INIT_BIT])
                        st_q <= lpi_pkg::ST_POLL;
                     else
                     begin
                        done_q <= 1'b1;
                        st_q   <= lpi_pkg::ST_READY;
                     end
                  end
               lpi_pkg::ST_READY:
                  if (go_q)
                  begin
                     if (uwr_q && uma_q == lpi_pkg::MA_SOFT_RESET)
                     begin
                        go_q <= 1'b0;
                        st_q <= lpi_pkg::ST_RESET;
                     end
                     else
                     begin
                        cmd_q  <= uwr_q ? lpi_pkg::CMD_MRW : lpi_pkg::CMD_MRR;
                        cs_n_q <= 1'b0;
                        ma_q   <= uma_q;
                        op_q   <= uop_q;
                        cnt_q  <= '0;
                        st_q   <= lpi_pkg::ST_UWAIT;
                     end
                  end
               lpi_pkg::ST_UWAIT:
                  if (cnt_q >= 20'h4)
                  begin
                     // Pending clears only once the read answer has landed
                     go_q <= 1'b0;
                     st_q <= lpi_pkg::ST_READY;
                  end
               default:
                  st_q <= lpi_pkg::ST_OFF;
            endcase
         end
         // A new order written in the cycle of a clear stays pending
         if (wr_acc && PADDR == lpi_pkg::APB_MRCMD && PWDATA[lpi_pkg::CMD_GO])
            go_q <= 1'b1;
      end
   end

   // Clock runs only at the fixed boot rate; no frequency change is offered
   assign LINK.mem_clk = mclk_q;
   assign LINK.cke     = cke_q;
   assign LINK.cs_n    = cs_n_q;
   assign LINK.cmd     = cmd_q;
   assign LINK.ma      = ma_q;
   assign LINK.op      = op_q;
endmodule
`default_nettype wire

// file: lpi_link_chk.sv
// Assertions on the command link between init controller and device
`timescale 1ns/10ps
`default_nettype none
module lpi_link_chk #(
   parameter int POST_CKE   = 200,
   parameter int POST_RESET = 40,
   parameter int AUTO_INIT  = lpi_pkg::AUTO_INIT_CYC
) (
   input  wire logic              CORE_CLK,
   input  wire logic              RST_N,
   input  wire logic              mem_clk,
   input  wire logic              cke,
   input  wire logic              cs_n,
   input  wire lpi_pkg::lpi_cmd_t cmd,
   input  wire logic [7:0]        ma,
   input  wire logic [7:0]        rd_data,
   input  wire logic              rd_valid,
   input  wire logic              rd_oe_n
);
   logic       mclk_q;
   logic       dai_q;
   logic [7:0] lma_q;
   int         low_q;
   int         edg_q;
   int         hi_q;
   int         rst_q;
   logic       evt;
   logic       rst_evt;
   assign evt     = mem_clk & ~mclk_q & cke & ~cs_n;
   assign rst_evt = evt && cmd == lpi_pkg::CMD_MRW && ma == lpi_pkg::MA_SOFT_RESET;
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);
   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         mclk_q <= 1'h0;
         low_q  <= 0;
         edg_q  <= 0;
         hi_q   <= 0;
         rst_q  <= POST_RESET;
      end
      else
      begin
         mclk_q <= mem_clk;
         low_q  <= cke ? 0 : low_q + 1;
         edg_q  <= cke ? 0 : edg_q + int'(mem_clk & ~mclk_q);
         hi_q   <= cke ? hi_q + 1 : 0;
         rst_q  <= rst_evt ? 0 : rst_q + 1;
      end
   end
   // Done is only known from a read of register 0 that shows the busy bit clear
   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         dai_q <= 1'h0;
         lma_q <= 8'h0;
      end
      else
      begin
         if (evt && cmd == lpi_pkg::CMD_MRR)
            lma_q <= ma;
         if (rst_evt)
            dai_q <= 1'h0;
         else if (rd_valid && lma_q == 8'h0 && !rd_data[0])
            dai_q <= 1'h1;
      end
   end
   // The device sees clock enable through a synchroniser, so allow it a few cycles
   property p_hiz; !cke [*4] |-> rd_oe_n; endproperty
   property p_cke_low; $rose(cke) |-> low_q >= lpi_pkg::CKE_LOW_CYC; endproperty
   property p_clk_stable; $rose(cke) |-> edg_q >= 5; endproperty
   property p_idle; rst_evt |-> hi_q >= POST_CKE; endproperty
   property p_nop_wait; evt && cmd != lpi_pkg::CMD_NOP && !rst_evt |-> rst_q >= POST_RESET;
   endproperty
   property p_reads_only; evt && !dai_q && !rst_evt
      |-> cmd inside {lpi_pkg::CMD_NOP, lpi_pkg::CMD_MRR, lpi_pkg::CMD_PDE, lpi_pkg::CMD_PDX};
   endproperty
   property p_answer; evt && cmd == lpi_pkg::CMD_MRR |-> ##[1:12] rd_valid; endproperty
   property p_kind; rd_valid && lma_q == 8'h0 |-> !rd_data[1]; endproperty
   property p_boot_clk; $changed(mem_clk) |=> $stable(mem_clk); endproperty
   property p_boot_slow; $changed(mem_clk) |-> ##[1:10] $changed(mem_clk); endproperty
   property p_init_time; rd_valid && lma_q == 8'h0 && rst_q >= AUTO_INIT |-> !rd_data[0];
   endproperty
   a_hiz: assert property (p_hiz) else $error("outputs driven with cke low");
   a_cke_low: assert property (p_cke_low) else $error("cke low too short");
   a_clk_stable: assert property (p_clk_stable) else $error("few clocks before cke");
   a_idle: assert property (p_idle) else $error("reset before idle wait");
   a_nop_wait: assert property (p_nop_wait) else $error("command too soon after reset");
   a_reads_only: assert property (p_reads_only) else $error("non-read before done");
   a_answer: assert property (p_answer) else $error("register read unanswered");
   a_kind: assert property (p_kind) else $error("device kind bit set");
   a_boot_clk: assert property (p_boot_clk) else $error("link clock too fast");
   a_boot_slow: assert property (p_boot_slow) else $error("link clock too slow");
   a_init_time: assert property (p_init_time) else $error("init done bit late");
   c_reset: cover property (rst_evt);
   c_done: cover property (rd_valid && lma_q == 8'h0 && !rd_data[0]);
   c_drive: cover property (evt && cmd == lpi_pkg::CMD_MRW && ma == lpi_pkg::MA_DRIVE);
endmodule
`default_nettype wire

// file: lpi_bench.sv
// Self-checking bench for the init controller and device pair
`timescale 1ns/10ps
`default_nettype none
module lpddr2_init_and_mode_regs_bench;
   localparam int PC = 200;
   localparam int PR = 40;
   // Shortened auto-init limit to match the shortened waits
   localparam int PA = 100;
   logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, fail_die, busy, bord, wrap;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [2:0]  blen, wrec;
   logic [3:0]  lat, drv;
   logic [15:0] cfg;
   int          bad_count, checks_done, n, k;
   logic [7:0]  ta [8] = '{8'h01, 8'h02, 8'h03, 8'h03, 8'h02, 8'h05, 8'h21, 8'h01};
   logic [7:0]  tw [8] = '{8'hbc, 8'h06, 8'h07, 8'h05, 8'h07, 8'hff, 8'hff, 8'h62};
   logic [15:0] te [8] = '{16'h9d12, 16'h9d62, 16'h9d67, 16'h9d67, 16'h9d67, 16'h9d67,
                           16'h9d67, 16'h4367};
   assign cfg = {blen, bord, wrap, wrec, lat, drv};
   lpi_link_if i_lpi_link_if ();
   lpi_init_ctrl #(.POST_CKE_CYC(PC), .POST_RESET_CYC(PR)) i_lpi_init_ctrl (.CORE_CLK(clk),
      .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .LINK(i_lpi_link_if));
   lpi_mem_dev #(.MAKER_CODE(8'h3c)) i_lpi_mem_dev (.CORE_CLK(clk), .RST_N(rst_n),
      .LINK(i_lpi_link_if), .FAIL_DIE(fail_die), .INIT_BUSY(busy), .BURST_LEN_CODE(blen),
      .BURST_ORDER(bord), .WRAP_OFF(wrap), .WRITE_RECOVERY(wrec), .LATENCY_CODE(lat),
      .DRIVE_CODE(drv));
   lpi_link_chk #(.POST_CKE(PC), .POST_RESET(PR), .AUTO_INIT(PA)) i_lpi_link_chk (
      .CORE_CLK(clk),
      .RST_N(rst_n), .mem_clk(i_lpi_link_if.mem_clk), .cke(i_lpi_link_if.cke),
      .cs_n(i_lpi_link_if.cs_n), .cmd(i_lpi_link_if.cmd), .ma(i_lpi_link_if.ma),
      .rd_data(i_lpi_link_if.rd_data), .rd_valid(i_lpi_link_if.rd_valid),
      .rd_oe_n(i_lpi_link_if.rd_oe_n));
   always #2.5 clk = ~clk;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // One APB transfer; the extra edge at the end keeps psel from toggling twice in a step
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel    <= 1'h1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'h1;
      @(posedge clk);
      while (pready !== 1'h1)
         @(posedge clk);
      r = prdata;
      psel    <= 1'h0;
      penable <= 1'h0;
      @(posedge clk);
   endtask
   task automatic mr(input logic w, input logic [7:0] a, input logic [7:0] d);
      apb(1'h1, lpi_pkg::APB_MRCMD, {1'h1, 14'h0, w, a, d});
      apb(1'h0, lpi_pkg::APB_STATUS, 32'h0);
      for (n = 0; r[9] !== 1'h0 && n < 100; n++)
         apb(1'h0, lpi_pkg::APB_STATUS, 32'h0);
      chk(r[9], 1'h0);
      if (!w)
         apb(1'h0, lpi_pkg::APB_MRDATA, 32'h0);
   endtask
   task automatic print_verdict();
      $display("Mismatches %0d, checks %0d", bad_count, checks_done);
      if (bad_count == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge clk);
      bad_count++;
      $display("ERROR %0t: timeout", $time);
      print_verdict();
   end
   initial
   begin
      clk = 0; rst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
      fail_die = 0; bad_count = 0; checks_done = 0;
      repeat (20) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      chk(cfg, 16'h4112);
      apb(1'h1, lpi_pkg::APB_CTRL, 32'h1);
      r = 32'h0;
      for (k = 0; r[8] !== 1'h1 && k < 1000; k++)
         apb(1'h0, lpi_pkg::APB_STATUS, 32'h0);
      chk(r[8], 1'h1);
      chk(busy, 1'h0);
      mr(1'h0, lpi_pkg::MA_INIT_STATUS, 8'h0);
      chk(r[1:0], 2'h0);
      for (k = 0; k < 8; k++)
      begin
         mr(1'h1, ta[k], tw[k]);
         chk(cfg, te[k]);
      end
      mr(1'h0, lpi_pkg::MA_MAKER, 8'h0);
      chk(r[7:0], 8'h3c);
      fail_die <= 1'h1;
      mr(1'h0, lpi_pkg::MA_TEST_MODE, 8'h0);
      chk(r[5], 1'h1);
      mr(1'h1, lpi_pkg::MA_SOFT_RESET, 8'h0);
      for (k = 0; busy !== 1'h1 && k < 20; k++)
         @(posedge clk);
      chk(busy, 1'h1);
      // Software must honour the post-reset quiet time before it polls
      repeat (PR) @(posedge clk);
      r = 32'h1;
      for (k = 0; r[0] !== 1'h0 && k < 50; k++)
         mr(1'h0, lpi_pkg::MA_INIT_STATUS, 8'h0);
      chk(r[0], 1'h0);
      chk(cfg, 16'h4112);
      mr(1'h1, lpi_pkg::MA_DRIVE, 8'h04);
      chk(drv, 4'h4);
      apb(1'h1, lpi_pkg::APB_CTRL, 32'h2);
      for (k = 0; {i_lpi_link_if.cke, i_lpi_link_if.rd_oe_n} !== 2'h1 && k < 40; k++)
         @(posedge clk);
      chk({i_lpi_link_if.cke, i_lpi_link_if.rd_oe_n}, 2'h1);
      print_verdict();
   end
endmodule
`default_nettype wire
